/* File: lpmc_ctrl.sv */
// mode selection, flash timer and fault reaction of the led flash driver
// assumes settings come from the i2c register engine on mclk (cfg_wr strobe)
// and that monitor pins are asynchronous levels from the analog side
module lpmc_ctrl import lpmc_pkg::*; #(
  parameter int MS_CYCLES = MS_CYC,
  parameter int ILSB_UA = 8000,
  parameter int FT_STEP_MS = 10
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl_pin,
  input wire logic strobe_pin,
  input wire logic uvlo_pin,
  input wire logic overtemp_pin,
  input wire logic [1:0] short_pin,
  input wire logic conv_ready_pin,
  input wire logic cfg_wr,
  input wire logic [1:0] cfg_mode_sel,
  input wire logic cfg_out_en,
  input wire logic cfg_cv_mode,
  input wire logic cfg_trig_en,
  input wire logic cfg_trig_level,
  input wire logic cfg_boost,
  input wire logic [3:0] cfg_flash_to_sel,
  input wire logic [1:0] cfg_ind_duty,
  input wire logic [7:0] sink1_current_level,
  input wire logic [7:0] sink2_current_level,
  input wire logic fault_rd,
  output logic [1:0] mode_sel,
  output logic out_en,
  output logic conv_en,
  output logic [1:0] sink_pins_en,
  output logic [7:0] sink1_code,
  output logic [7:0] sink2_code,
  output logic fault_short,
  output logic fault_overtemp,
  output logic fault_timeout,
  output logic i2c_rst_n,
  output logic shutdown
);
  if (ILSB_UA < 1 || ILSB_UA > 65000 || FT_STEP_MS < 1
      || FT_STEP_MS * 16 > 1023) begin : g_chk
    $error("lpmc_ctrl parameter out of range");
  end

  localparam logic [6:0] SCL_LIM = 7'(SCL_TO_MAX_MS);
  localparam logic [2:0] SC_LAST = 3'(SHORT_FILT - 1);

  typedef struct packed {
    logic [SY_W-1:0] sy1;
    logic [SY_W-1:0] sy2;
    logic strobe_d;
    lpmc_state_t st;
    lpmc_cfg_t cfg;
    logic f_short;
    logic f_ot;
    logic f_to;
    logic [1:0] ch_off;
    logic flash;
    logic [9:0] ftimer;
    logic [6:0] scl_ms;
    logic [1:0][2:0] sc_cnt;
    logic conv_en;
    logic [1:0] sink_en;
    logic [1:0][7:0] code;
    logic rel;
    logic shdn;
  } lpmc_ctrl_state_t;

  localparam lpmc_ctrl_state_t ST_RESET = '{st: ST_SHDN, shdn: 1'b1,
                                            default: '0};

  lpmc_tick_if tk ();
  lpmc_tick #(.MS_CYCLES(MS_CYCLES)) u_tick (
    .mclk(mclk),
    .rst_n(rst_n),
    .tk(tk.src)
  );

  function automatic logic above_thr(input logic [7:0] c, input logic b);
    return (24'(c) * 24'(ILSB_UA))
           > (b ? 24'(SHORT_UA_BOOST) : 24'(SHORT_UA_NORM));
  endfunction : above_thr

  function automatic logic [9:0] flash_dur(input logic [3:0] f);
    return 10'({6'h0, f} + 10'h1) * 10'(FT_STEP_MS);
  endfunction : flash_dur

  // current code actually used in each mode
  function automatic logic [7:0] eff_code(input logic [1:0] m,
                                          input logic [7:0] l);
    unique case (m)
      MODE_IND: return {2'b00, l[5:0]};
      MODE_ASSIST: return {1'b0, l[6:0]};
      MODE_FLASH: return l;
      MODE_OFF: return 8'h00;
    endcase
  endfunction : eff_code

  lpmc_ctrl_state_t r_reg;
  lpmc_ctrl_state_t r_next;
  lpmc_cfg_t cfg_in;
  logic scl, strobe, uvlo, ot, ready, strobe_rise, armed, scl_to, act, pwm_on;
  logic [1:0] watch, trip, live;

  assign scl = r_reg.sy2[SY_SCL];
  assign strobe = r_reg.sy2[SY_STB];
  assign uvlo = r_reg.sy2[SY_UV];
  assign ot = r_reg.sy2[SY_OT];
  assign ready = r_reg.sy2[SY_RDY];
  assign strobe_rise = strobe && !r_reg.strobe_d;
  assign armed = r_reg.cfg.mode != MODE_OFF && r_reg.cfg.out_en;
  assign scl_to = armed && !scl && r_reg.scl_ms == SCL_LIM;
  assign live = ~r_reg.ch_off & {|r_reg.cfg.lvl2, |r_reg.cfg.lvl1};
  assign cfg_in = '{mode: cfg_mode_sel, out_en: cfg_out_en,
                    cv: cfg_cv_mode, trig_en: cfg_trig_en,
                    trig_lvl: cfg_trig_level, boost: cfg_boost,
                    fto: cfg_flash_to_sel, duty: cfg_ind_duty,
                    lvl1: sink1_current_level, lvl2: sink2_current_level};

  // comparator is only trusted once the converter is up and current flows
  for (genvar i = 0; i < 2; i++) begin : g_sc
    assign watch[i] = r_reg.sy2[SY_SC0+i] && ready && r_reg.sink_en[i]
                      && above_thr(r_reg.code[i], r_reg.cfg.boost);
    assign trip[i] = watch[i] && r_reg.sc_cnt[i] == SC_LAST;
  end

  always_comb begin
    r_next = r_reg;
    r_next.sy1 = {conv_ready_pin, short_pin, overtemp_pin, uvlo_pin,
                  strobe_pin, scl_pin};
    r_next.sy2 = r_reg.sy1;
    r_next.strobe_d = strobe;
    if (fault_rd) begin
      r_next.f_short = 1'b0;
      r_next.f_ot = 1'b0;
      r_next.f_to = 1'b0;
    end
    if (armed && !scl) begin
      if (tk.ms_tick && r_reg.scl_ms != SCL_LIM) begin
        r_next.scl_ms = r_reg.scl_ms + 7'h1;
      end
    end else begin
      r_next.scl_ms = 7'h0;
    end
    if (!armed) begin
      r_next.ch_off = 2'b00;
    end
    for (int i = 0; i < 2; i++) begin
      if (!watch[i]) begin
        r_next.sc_cnt[i] = 3'h0;
      end else if (!trip[i]) begin
        r_next.sc_cnt[i] = r_reg.sc_cnt[i] + 3'h1;
      end
    end
    unique case (r_reg.st)
      ST_SHDN: begin
        r_next.cfg = CFG_DEFAULT;
        r_next.flash = 1'b0;
        if (scl && !uvlo) begin
          r_next.st = ST_ACT;
          r_next.scl_ms = 7'h0;
        end
      end
      ST_OTEMP: begin
        r_next.flash = 1'b0;
        if (cfg_wr) begin
          r_next.cfg = cfg_in;
        end
        if (!ot) begin
          r_next.st = ST_ACT;
          if (r_reg.cfg.cv) begin
            r_next.cfg.mode = MODE_OFF;
            r_next.cfg.out_en = 1'b0;
          end
        end
      end
      ST_ACT: begin
        if (cfg_wr) begin
          r_next.cfg = cfg_in;
        end
        if (ot) begin
          // settings kept so that the block can resume by itself when cv is clear; with cv set, mode and out_en are cleared on exit
          r_next.st = ST_OTEMP;
          r_next.f_ot = 1'b1;
          r_next.flash = 1'b0;
        end else begin
          if (!(armed && r_reg.cfg.mode == MODE_FLASH)) begin
            r_next.flash = 1'b0;
          end else if (!r_reg.flash) begin
            if (!r_reg.cfg.trig_en
                || (r_reg.cfg.trig_lvl ? strobe : strobe_rise)) begin
              r_next.flash = 1'b1;
              r_next.ftimer = 10'h0;
            end
          end else if (r_reg.cfg.trig_en && r_reg.cfg.trig_lvl
                       && !strobe) begin
            r_next.flash = 1'b0;
          end else if (r_reg.ftimer >= flash_dur(r_reg.cfg.fto)) begin
            r_next.flash = 1'b0;
            if (!r_reg.cfg.trig_en || r_reg.cfg.trig_lvl) begin
              r_next.f_to = 1'b1;
              r_next.cfg.mode = MODE_OFF;
              r_next.cfg.out_en = 1'b0;
            end
          end else if (tk.ms_tick) begin
            r_next.ftimer = r_reg.ftimer + 10'h1;
          end
          if (|trip) begin
            r_next.f_short = 1'b1;
            if ((live & ~trip) != 2'b00) begin
              r_next.ch_off = r_reg.ch_off | trip;
            end else begin
              r_next.cfg.mode = MODE_OFF;
              r_next.cfg.out_en = 1'b0;
              r_next.flash = 1'b0;
            end
          end
        end
      end
      default: begin
        r_next.st = ST_SHDN;
      end
    endcase
    if (scl_to || uvlo) begin
      r_next.st = ST_SHDN;
      r_next.cfg = CFG_DEFAULT;
      r_next.flash = 1'b0;
    end
    // outputs follow the settled next state so a fault acts in one edge
    act = r_next.st == ST_ACT && r_next.cfg.out_en
          && r_next.cfg.mode != MODE_OFF
          && (r_next.cfg.mode != MODE_FLASH || r_next.flash);
    pwm_on = tk.pwm_slot <= {2'b00, r_next.cfg.duty};
    for (int i = 0; i < 2; i++) begin
      r_next.sink_en[i] = act && !r_next.ch_off[i]
                          && (r_next.cfg.mode != MODE_IND || pwm_on);
      r_next.code[i] = r_next.sink_en[i]
          ? eff_code(r_next.cfg.mode, i == 0 ? r_next.cfg.lvl1
                                             : r_next.cfg.lvl2)
          : 8'h00;
    end
    r_next.conv_en = act && r_next.ch_off != 2'b11;
    r_next.rel = r_next.st != ST_SHDN;
    r_next.shdn = r_next.st == ST_SHDN;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= ST_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  assign mode_sel = r_reg.cfg.mode;
  assign out_en = r_reg.cfg.out_en;
  assign conv_en = r_reg.conv_en;
  assign sink_pins_en = r_reg.sink_en;
  assign sink1_code = r_reg.code[0];
  assign sink2_code = r_reg.code[1];
  assign fault_short = r_reg.f_short;
  assign fault_overtemp = r_reg.f_ot;
  assign fault_timeout = r_reg.f_to;
  assign i2c_rst_n = r_reg.rel;
  assign shutdown = r_reg.shdn;

  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  logic quiet;
  logic edge_ready;
  assign quiet = r_reg.st == ST_ACT && !uvlo && !ot && !scl_to;
  assign edge_ready = quiet && armed && r_reg.cfg.mode == MODE_FLASH
                      && r_reg.cfg.trig_en && !r_reg.cfg.trig_lvl
                      && !r_reg.flash && trip == 2'b00;

  sequence s_trig_rise;
    !strobe ##1 (strobe && edge_ready);
  endsequence

  a_ot_stop: assert property ((r_reg.st == ST_ACT && ot && !uvlo)
      |=> (!conv_en && sink_pins_en == 2'b00 && fault_overtemp))
    else $error("overtemp did not stop outputs");
  a_uvlo_hold: assert property (uvlo
      |=> (mode_sel == MODE_OFF && !out_en && shutdown)
          ##1 (mode_sel == MODE_OFF && !out_en))
    else $error("undervoltage did not hold defaults");
  a_scl_shdn: assert property (scl_to
      |=> (shutdown && sink1_code == 8'h00 && sink2_code == 8'h00
           && !out_en))
    else $error("scl timeout did not shut down");
  a_scl_wake: assert property ((shutdown && scl && !uvlo)
      |=> (i2c_rst_n && r_reg.scl_ms == 7'h0))
    else $error("scl high did not release reset");
  a_assist_msb: assert property ((mode_sel == MODE_ASSIST)
      |-> (!sink1_code[7] && !sink2_code[7]))
    else $error("assist used top current bit");
  a_ind_bits: assert property ((mode_sel == MODE_IND)
      |-> (sink1_code[7:6] == 2'b00 && sink2_code[7:6] == 2'b00))
    else $error("indicator used upper current bits");
  a_standby_zero: assert property ((!out_en)
      |-> (sink_pins_en == 2'b00 && !conv_en && sink1_code == 8'h00
           && sink2_code == 8'h00))
    else $error("standby drove a sink");
  a_timer_cut: assert property ((quiet && r_reg.flash && trip == 2'b00
      && (!r_reg.cfg.trig_en || (r_reg.cfg.trig_lvl && strobe))
      && r_reg.ftimer >= flash_dur(r_reg.cfg.fto))
      |=> (fault_timeout && !out_en && mode_sel == MODE_OFF
           && sink_pins_en == 2'b00))
    else $error("flash timeout not enforced");
  a_edge_start: assert property (s_trig_rise
      |=> (r_reg.flash && r_reg.ftimer == 10'h0))
    else $error("rising trigger did not start flash");
  a_short_one: assert property ((quiet && trip == 2'b01
      && live == 2'b11) |=> (r_reg.ch_off[0] && fault_short
      && !sink_pins_en[0] && out_en))
    else $error("single short handling wrong");
endmodule : lpmc_ctrl

/* File: lpmc_ctrl_tb.sv */
// self-checking bench for the flash driver mode and protection control
// assumes MS_CYCLES=40, so 1 ms is 40 cycles and a timeout step is 400
module lpmc_ctrl_tb import lpmc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_n, run, scl_pin, strobe_pin, uvlo_pin, overtemp_pin;
  logic conv_ready_pin, cfg_wr, cfg_out_en, cfg_cv_mode, cfg_trig_en;
  logic cfg_trig_level, cfg_boost, fault_rd, out_en, conv_en;
  logic fault_short, fault_overtemp, fault_timeout, i2c_rst_n, shutdown;
  logic [1:0] short_pin, cfg_mode_sel, cfg_ind_duty, mode_sel, sink_pins_en;
  logic [3:0] cfg_flash_to_sel;
  logic [7:0] sink1_current_level, sink2_current_level;
  logic [7:0] sink1_code, sink2_code, c;
  int n_errors, tests_run, k, d;

  lpmc_host host (.mclk, .run, .scl_pin);
  lpmc_ctrl #(.MS_CYCLES(40)) dut (.mclk, .rst_n, .scl_pin, .strobe_pin,
    .uvlo_pin, .overtemp_pin, .short_pin, .conv_ready_pin, .cfg_wr,
    .cfg_mode_sel, .cfg_out_en, .cfg_cv_mode, .cfg_trig_en, .cfg_trig_level,
    .cfg_boost, .cfg_flash_to_sel, .cfg_ind_duty, .sink1_current_level,
    .sink2_current_level, .fault_rd, .mode_sel, .out_en, .conv_en,
    .sink_pins_en, .sink1_code, .sink2_code, .fault_short, .fault_overtemp,
    .fault_timeout, .i2c_rst_n, .shutdown);

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rng(input string nm, input int lo, input int hi,
    input int v);
    tests_run++;
    if (v < lo || v > hi) begin
      n_errors++;
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, v);
    end
  endtask : rng

  // settle past the edge so flops have landed before sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic wr(input logic [1:0] m, input logic oe, input logic cv,
    input logic te, input logic tl, input logic [1:0] du,
    input logic [7:0] a, input logic [7:0] b);
    @(posedge mclk);
    cfg_wr <= 1'b1;
    cfg_mode_sel <= m;
    cfg_out_en <= oe;
    cfg_cv_mode <= cv;
    cfg_trig_en <= te;
    cfg_trig_level <= tl;
    cfg_ind_duty <= du;
    sink1_current_level <= a;
    sink2_current_level <= b;
    @(posedge mclk);
    cfg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd;
    @(posedge mclk);
    fault_rd <= 1'b1;
    @(posedge mclk);
    fault_rd <= 1'b0;
    #1;
  endtask : rd

  task automatic wake;
    for (k = 0; k < 100 && i2c_rst_n !== 1'b1; k++) cyc(1);
    chk("i2c_rst_n", 1, i2c_rst_n);
  endtask : wake

  task automatic t_assist;
    wr(MODE_ASSIST, 1, 0, 0, 0, 0, 8'hff, 8'h81);
    cyc(2);
    chk("sink1_code", 8'h7f, sink1_code);
    chk("sink2_code", 8'h01, sink2_code);
    wr(MODE_ASSIST, 0, 0, 0, 0, 0, 8'hff, 8'h81);
    cyc(2);
    chk("standby code", 0, sink1_code | sink2_code);
    chk("standby sinks", 0, sink_pins_en);
    $display("test assist done");
  endtask : t_assist

  task automatic t_ind;
    for (d = 0; d < 4; d++) begin
      wr(MODE_IND, 1, 0, 0, 0, d[1:0], 8'hff, 8'hff);
      cyc(4);
      k = 0;
      c = 8'h00;
      // a full 1280-cycle window counts the on time whatever the phase
      repeat (1280) begin
        cyc(1);
        if (sink_pins_en[0] === 1'b1) begin
          k++;
          c = sink1_code;
        end
      end
      chk("ind code", 8'h3f, c);
      rng("pwm on cycles", (d + 1) * 80, (d + 1) * 80, k);
    end
    $display("test indicator done");
  endtask : t_ind

  task automatic t_otemp;
    wr(MODE_ASSIST, 1, 0, 0, 0, 0, 8'h10, 8'h10);
    @(posedge mclk);
    overtemp_pin <= 1'b1;
    cyc(3);
    chk("ot conv_en", 0, conv_en);
    chk("ot sinks", 0, sink_pins_en);
    chk("ot flag", 1, fault_overtemp);
    @(posedge mclk);
    overtemp_pin <= 1'b0;
    cyc(3);
    chk("resume conv_en", 1, conv_en);
    rd();
    chk("flag after read", 0, fault_overtemp);
    wr(MODE_ASSIST, 1, 1, 0, 0, 0, 8'h10, 8'h10);
    @(posedge mclk);
    overtemp_pin <= 1'b1;
    cyc(4);
    overtemp_pin <= 1'b0;
    cyc(4);
    chk("cv no restart", 0, {mode_sel, out_en, conv_en});
    rd();
    $display("test overtemp done");
  endtask : t_otemp

  task automatic t_short;
    cfg_boost <= 1'b1;
    wr(MODE_ASSIST, 1, 0, 0, 0, 0, 8'h01, 8'h10);
    short_pin <= 2'b01;
    cyc(20);
    chk("short below threshold", 0, fault_short);
    short_pin <= 2'b00;
    wr(MODE_ASSIST, 1, 0, 0, 0, 0, 8'h10, 8'h10);
    short_pin <= 2'b01;
    cyc(14);
    chk("short flag", 1, fault_short);
    chk("one sink off", 2'b10, sink_pins_en);
    chk("conv on", 1, conv_en);
    rd();
    short_pin <= 2'b10;
    cyc(14);
    chk("last short", 0, {mode_sel, out_en, conv_en});
    chk("short flag 2", 1, fault_short);
    short_pin <= 2'b00;
    cfg_boost <= 1'b0;
    rd();
    $display("test short done");
  endtask : t_short

  task automatic t_flash;
    wr(MODE_FLASH, 1, 0, 0, 0, 0, 8'hff, 8'hff);
    cyc(1);
    chk("flash code", 8'hff, sink1_code);
    for (k = 0; k < 600 && out_en !== 1'b0; k++) cyc(1);
    rng("flash length", 360, 405, k);
    chk("timeout flag", 1, fault_timeout);
    chk("mode off", MODE_OFF, mode_sel);
    rd();
    $display("test flash done");
  endtask : t_flash

  task automatic t_level;
    wr(MODE_FLASH, 1, 0, 1, 1, 0, 8'hff, 8'hff);
    cyc(4);
    chk("idle sinks", 0, sink_pins_en);
    strobe_pin <= 1'b1;
    cyc(3);
    chk("level on", 2'b11, sink_pins_en);
    cyc(100);
    strobe_pin <= 1'b0;
    cyc(3);
    chk("level off", 0, {sink_pins_en, fault_timeout});
    strobe_pin <= 1'b1;
    for (k = 0; k < 600 && out_en !== 1'b0; k++) cyc(1);
    rng("level cut", 360, 405, k);
    chk("cut flag", 1, fault_timeout);
    strobe_pin <= 1'b0;
    rd();
    $display("test level done");
  endtask : t_level

  task automatic t_edge;
    // a longer timeout setting proves the length follows the register
    cfg_flash_to_sel <= 4'h1;
    wr(MODE_FLASH, 1, 0, 1, 0, 0, 8'hff, 8'hff);
    cyc(2);
    strobe_pin <= 1'b1;
    cyc(4);
    chk("edge on", 2'b11, sink_pins_en);
    strobe_pin <= 1'b0;
    for (k = 0; k < 1000 && sink_pins_en !== 2'b00; k++) cyc(1);
    rng("edge length", 760, 805, k);
    chk("edge armed", 1, out_en);
    chk("edge no flag", 0, fault_timeout);
    cfg_flash_to_sel <= 4'h0;
    $display("test edge done");
  endtask : t_edge

  task automatic t_uvlo;
    wr(MODE_ASSIST, 1, 0, 0, 0, 0, 8'h10, 8'h10);
    uvlo_pin <= 1'b1;
    cyc(4);
    chk("uv shutdown", 1, shutdown);
    wr(MODE_ASSIST, 1, 0, 0, 0, 0, 8'h10, 8'h10);
    cyc(2);
    chk("uv defaults", 0, {mode_sel, out_en, sink1_code});
    uvlo_pin <= 1'b0;
    wake();
    $display("test uvlo done");
  endtask : t_uvlo

  task automatic t_scl;
    wr(MODE_ASSIST, 1, 0, 0, 0, 0, 8'h10, 8'h10);
    run <= 1'b0;
    for (k = 0; k < 4300 && shutdown !== 1'b1; k++) cyc(1);
    rng("scl timeout", 3900, 4100, k);
    chk("scl defaults", 0, {mode_sel, out_en, sink1_code});
    chk("scl sink2", 0, sink2_code);
    run <= 1'b1;
    wake();
    $display("test scl loss done");
  endtask : t_scl

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    n_errors = 0;
    tests_run = 0;
    rst_n = 1'b0;
    run = 1'b1;
    {strobe_pin, uvlo_pin, overtemp_pin, cfg_wr, fault_rd} = 5'h00;
    {cfg_out_en, cfg_cv_mode, cfg_trig_en, cfg_trig_level} = 4'h0;
    conv_ready_pin = 1'b1;
    cfg_boost = 1'b0;
    short_pin = 2'h0;
    cfg_mode_sel = 2'h0;
    cfg_ind_duty = 2'h0;
    cfg_flash_to_sel = 4'h0;
    sink1_current_level = 8'h00;
    sink2_current_level = 8'h00;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    wake();
    t_assist();
    t_ind();
    t_otemp();
    t_short();
    t_flash();
    t_level();
    t_edge();
    t_uvlo();
    t_scl();
    end_of_test();
  end
endmodule : lpmc_ctrl_tb

/* File: lpmc_host.sv */
// host side model: the i2c master, seen only through its scl line
// assumes the bench lowers run to mimic a powered-off host
module lpmc_host (
  input wire logic mclk,
  input wire logic run,
  output logic scl_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_reg;
  initial begin
    scl_pin = 1'b1;
    cnt_reg = 4'h0;
  end
  // steady toggling keeps the bus-loss timer quiet
  always @(posedge mclk) begin
    cnt_reg <= cnt_reg + 4'h1;
    if (!run) begin
      scl_pin <= 1'b0;
    end else if (cnt_reg == 4'hf) begin
      scl_pin <= ~scl_pin;
    end
  end
endmodule : lpmc_host

/* File: lpmc_pkg.sv */
// shared constants and types for the flash driver protection/mode control
// assumes a single 40 MHz clock domain; analog monitors arrive as raw levels
package lpmc_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int PWM_HZ = 31250;
  localparam int PWM_SLOTS = 16;
  localparam int PWM_SLOT_CYC = CLK_HZ / PWM_HZ / PWM_SLOTS;
  localparam int MS_CYC = CLK_HZ / 1000;
  localparam int SCL_TO_MIN_MS = 35;
  localparam int SCL_TO_MAX_MS = 100;
  localparam int SHORT_UA_NORM = 14000;
  localparam int SHORT_UA_BOOST = 15600;
  localparam int SHORT_FILT = 8;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_IND = 2'h1;
  localparam logic [1:0] MODE_ASSIST = 2'h2;
  localparam logic [1:0] MODE_FLASH = 2'h3;
  // synchroniser bit positions
  localparam int SY_SCL = 0;
  localparam int SY_STB = 1;
  localparam int SY_UV = 2;
  localparam int SY_OT = 3;
  localparam int SY_SC0 = 4;
  localparam int SY_RDY = 6;
  localparam int SY_W = 7;
  typedef enum logic [1:0] {
    ST_SHDN = 2'b00,
    ST_ACT = 2'b01,
    ST_OTEMP = 2'b10
  } lpmc_state_t;
  typedef struct packed {
    logic [1:0] mode;
    logic out_en;
    logic cv;
    logic trig_en;
    logic trig_lvl;
    logic boost;
    logic [3:0] fto;
    logic [1:0] duty;
    logic [7:0] lvl1;
    logic [7:0] lvl2;
  } lpmc_cfg_t;
  localparam lpmc_cfg_t CFG_DEFAULT = '0;
endpackage : lpmc_pkg

/* File: lpmc_tick.sv */
// divider: 1 ms enable pulse and the 16-slot indicator pwm phase
// assumes mclk at 40 MHz; 16 slots of 80 cycles give a 31.25 kHz pwm period
module lpmc_tick import lpmc_pkg::*; #(
  parameter int MS_CYCLES = MS_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  lpmc_tick_if.src tk
);
  if (MS_CYCLES < 2 || MS_CYCLES > 65536) begin : g_chk
    $error("MS_CYCLES out of range");
  end

  typedef struct packed {
    logic [15:0] ms_cnt;
    logic ms_tick;
    logic [6:0] sub;
    logic [3:0] slot;
  } lpmc_tick_state_t;

  lpmc_tick_state_t r_reg;
  lpmc_tick_state_t r_next;

  always_comb begin
    r_next = r_reg;
    r_next.ms_tick = 1'b0;
    if (r_reg.ms_cnt == 16'(MS_CYCLES - 1)) begin
      r_next.ms_cnt = 16'h0;
      r_next.ms_tick = 1'b1;
    end else begin
      r_next.ms_cnt = r_reg.ms_cnt + 16'h1;
    end
    if (r_reg.sub == 7'(PWM_SLOT_CYC - 1)) begin
      r_next.sub = 7'h0;
      r_next.slot = r_reg.slot + 4'h1;
    end else begin
      r_next.sub = r_reg.sub + 7'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign tk.ms_tick = r_reg.ms_tick;
  assign tk.pwm_slot = r_reg.slot;
endmodule : lpmc_tick

/* File: lpmc_tick_if.sv */
// timebase signals passed from the divider to the controller
// assumes both ends run on mclk
interface lpmc_tick_if;
  logic ms_tick;
  logic [3:0] pwm_slot;
  modport src (output ms_tick, output pwm_slot);
  modport snk (input ms_tick, input pwm_slot);
endinterface : lpmc_tick_if
